// File: common/scrb_map.vh
// register map, field positions and power-up values of the serial control bank
`ifndef SCRB_MAP_VH
`define SCRB_MAP_VH

// serial word layout
`define SCRB_WORD_W      24
`define SCRB_ADDR_W      4
`define SCRB_DATA_W      20
`define SCRB_ADDR_LSB    0
`define SCRB_DATA_LSB    4

// register addresses
`define SCRB_ADDR_MAIN   4'h0
`define SCRB_ADDR_REF    4'h1
`define SCRB_ADDR_CFG    4'h2
`define SCRB_ADDR_OPERATIONAL_CONTROL 4'h3
`define SCRB_ADDR_TEST   4'h4

// operational_control fields
`define SCRB_OP_SOFT_ON  0
`define SCRB_OP_TX_ON    1
`define SCRB_OP_REGISTER_RETAINING_STANDBY_ON  2
`define SCRB_OP_MODTYPE  3
`define SCRB_OP_BUF_EN   4
`define SCRB_OP_SIDEBAND 5
`define SCRB_OP_IFG_LSB  6
`define SCRB_OP_IFG_MSB  8
`define SCRB_OP_MODE_LSB 11
`define SCRB_OP_MODE_MSB 12
`define SCRB_OP_CP_BOOST 13
`define SCRB_OP_LO_PICK  15

// band-mode codes
`define SCRB_MODE_FM     2'h0
`define SCRB_MODE_CELL   2'h1
`define SCRB_MODE_PCS    2'h3

// configuration fields
`define SCRB_CFG_BUF_DIV 0
`define SCRB_CFG_BB_LVL  1

// power-up values
`define SCRB_OPERATIONAL_CONTROL_RST  20'h0892F

`endif

// File: hdl/scrb_sync.v
// two-stage synchroniser for one asynchronous input
`default_nettype none

module scrb_sync
#(
  parameter RESET_VAL = 1'b0
)
(
  input  wire ref_clk,
  input  wire rst_n,
  input  wire async_in,
  output reg  sync_out
);

  reg stage1_reg;

  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage1_reg <= RESET_VAL;
      sync_out   <= RESET_VAL;
    end
    else
    begin
      stage1_reg <= async_in;
      sync_out   <= stage1_reg;
    end
  end

endmodule

`default_nettype wire

// File: hdl/scrb_top.v
// serial control port and register bank with operational-control decode
`include "scrb_map.vh"
`default_nettype none

// How it works
// - five writable registers, each loaded from one 24-bit serial word
// - low 4 bits of the word are the address, upper 20 the data
// - don't-care bits are stored but steer nothing
// - while select is low, one bit shifts in per serial clock rise
// - select rising copies the word into the addressed register
// - main and reference divider registers set the PLL ratios
// - soft shutdown bit low powers down all but serial port, restores defaults
// - transmit standby low disables modulator and upconverter, like the gate pin
// - full standby low powers down all but registers, bias and serial port
// - modulation-path bit 0 selects direct oscillator modulation
// - buffer-enable bit turns the buffered oscillator output on or off
// - 3-bit intermediate gain step, about 2 dB per code
// - sideband bit 1 upper sideband, 0 lower sideband
// - band mode 00 FM, 01 low-band cellular, 11 high-band; 10 unused
// - charge-pump boost bit keeps boost current after acquisition
// - oscillator port bit 15: 1 low-band input, 0 high-band input
// - hardware powerdown pin low kills everything and loses registers
// - buffer-divide bit selects full or half oscillator frequency
// - baseband-level bit selects reduced baseband input level
module scrb_top
#(
  parameter [19:0] MAIN_RST = 20'h00000,
  parameter [19:0] REF_RST  = 20'h00000,
  parameter [19:0] CFG_RST  = 20'h00000,
  parameter [19:0] TEST_RST = 20'h00000
)
(
  input  wire        ref_clk,
  input  wire        rst_n,
  input  wire        ser_select_n,
  input  wire        ser_clk,
  input  wire        ser_data,
  input  wire        hardware_powerdown_pin_n,
  input  wire        transmit_gate_pin,
  output reg  [19:0] main_divider_ratio,
  output reg  [19:0] reference_divider_ratio,
  output reg  [19:0] config_word,
  output reg  [19:0] test_word,
  output reg         serial_port_on,
  output reg         bias_on,
  output reg         synth_on,
  output reg         upconverter_on,
  output reg         iq_modulator_on,
  output reg         direct_vco_mod,
  output reg         buffered_osc_output,
  output reg         buffered_osc_half,
  output reg  [2:0]  intermediate_gain_step,
  output reg         upper_sideband,
  output reg         fm_mode,
  output reg         low_band_driver_output,
  output reg         high_band_driver_output,
  output reg         charge_pump_boost_hold,
  output reg         oscillator_port_pick,
  output reg         baseband_level_select
);

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  wire sel_s;
  wire sclk_s;
  wire sdat_s;
  wire hw_on_s;
  wire gate_s;

  scrb_sync #(.RESET_VAL(1'b1)) u_sync_sel
  (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .async_in (ser_select_n),
    .sync_out (sel_s)
  );

  scrb_sync #(.RESET_VAL(1'b0)) u_sync_clk
  (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .async_in (ser_clk),
    .sync_out (sclk_s)
  );

  scrb_sync #(.RESET_VAL(1'b0)) u_sync_dat
  (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .async_in (ser_data),
    .sync_out (sdat_s)
  );

  scrb_sync #(.RESET_VAL(1'b0)) u_sync_hw
  (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .async_in (hardware_powerdown_pin_n),
    .sync_out (hw_on_s)
  );

  scrb_sync #(.RESET_VAL(1'b0)) u_sync_gate
  (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .async_in (transmit_gate_pin),
    .sync_out (gate_s)
  );

  // ------------------------------------------------------------
  // edge detection
  // ------------------------------------------------------------
  reg sel_d_reg;
  reg sclk_d_reg;

  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sel_d_reg  <= 1'b1;
      sclk_d_reg <= 1'b0;
    end
    else
    begin
      sel_d_reg  <= sel_s;
      sclk_d_reg <= sclk_s;
    end
  end

  wire sclk_rise = sclk_s & ~sclk_d_reg;
  wire sel_rise  = sel_s & ~sel_d_reg;

  // ------------------------------------------------------------
  // shift register
  // ------------------------------------------------------------
  reg  [`SCRB_WORD_W-1:0] shift_reg;
  reg  [`SCRB_WORD_W-1:0] shift_next;

  always @*
  begin
    shift_next = shift_reg;
    if (!hw_on_s)
      shift_next = {`SCRB_WORD_W{1'b0}};
    else if (sclk_rise && !sel_s)
      shift_next = {shift_reg[`SCRB_WORD_W-2:0], sdat_s};
  end

  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      shift_reg <= {`SCRB_WORD_W{1'b0}};
    else
      shift_reg <= shift_next;
  end

  wire [`SCRB_ADDR_W-1:0] word_addr = shift_reg[`SCRB_ADDR_LSB +: `SCRB_ADDR_W];
  wire [`SCRB_DATA_W-1:0] word_data = shift_reg[`SCRB_DATA_LSB +: `SCRB_DATA_W];
  wire                    load      = sel_rise & hw_on_s;

  // ------------------------------------------------------------
  // register bank
  // ------------------------------------------------------------
  reg  [19:0] main_reg;
  reg  [19:0] ref_reg;
  reg  [19:0] cfg_reg;
  reg  [19:0] op_reg;
  reg  [19:0] test_reg;
  reg  [19:0] main_next;
  reg  [19:0] ref_next;
  reg  [19:0] cfg_next;
  reg  [19:0] op_next;
  reg  [19:0] test_next;

  always @*
  begin
    main_next = main_reg;
    ref_next  = ref_reg;
    cfg_next  = cfg_reg;
    op_next   = op_reg;
    test_next = test_reg;
    if (load)
    begin
      case (word_addr)
        `SCRB_ADDR_MAIN:   main_next = word_data;
        `SCRB_ADDR_REF:    ref_next  = word_data;
        `SCRB_ADDR_CFG:    cfg_next  = word_data;
        `SCRB_ADDR_OPERATIONAL_CONTROL: op_next   = word_data;
        `SCRB_ADDR_TEST:   test_next = word_data;
        default:           op_next   = op_reg;
      endcase
    end
    if (!op_next[`SCRB_OP_SOFT_ON])
    begin
      main_next = MAIN_RST;
      ref_next  = REF_RST;
      cfg_next  = CFG_RST;
      test_next = TEST_RST;
      op_next   = `SCRB_OPERATIONAL_CONTROL_RST;
      op_next[`SCRB_OP_SOFT_ON] = 1'b0;
    end
    if (!hw_on_s)
    begin
      main_next = MAIN_RST;
      ref_next  = REF_RST;
      cfg_next  = CFG_RST;
      test_next = TEST_RST;
      op_next   = `SCRB_OPERATIONAL_CONTROL_RST;
    end
  end

  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      main_reg <= MAIN_RST;
      ref_reg  <= REF_RST;
      cfg_reg  <= CFG_RST;
      op_reg   <= `SCRB_OPERATIONAL_CONTROL_RST;
      test_reg <= TEST_RST;
    end
    else
    begin
      main_reg <= main_next;
      ref_reg  <= ref_next;
      cfg_reg  <= cfg_next;
      op_reg   <= op_next;
      test_reg <= test_next;
    end
  end

  // ------------------------------------------------------------
  // operational decode
  // ------------------------------------------------------------
  // only named fields are decoded
  wire [1:0] band_mode = op_reg[`SCRB_OP_MODE_MSB:`SCRB_OP_MODE_LSB];
  wire       core_on   = hw_on_s & op_reg[`SCRB_OP_SOFT_ON];
  wire       synth_ok  = core_on & op_reg[`SCRB_OP_REGISTER_RETAINING_STANDBY_ON];
  wire       tx_ok     = synth_ok & op_reg[`SCRB_OP_TX_ON] & gate_s;

  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      main_divider_ratio      <= MAIN_RST;
      reference_divider_ratio <= REF_RST;
      config_word             <= CFG_RST;
      test_word               <= TEST_RST;
      serial_port_on          <= 1'b0;
      bias_on                 <= 1'b0;
      synth_on                <= 1'b0;
      upconverter_on          <= 1'b0;
      iq_modulator_on         <= 1'b0;
      direct_vco_mod          <= 1'b0;
      buffered_osc_output     <= 1'b0;
      buffered_osc_half       <= 1'b0;
      intermediate_gain_step  <= 3'h0;
      upper_sideband          <= 1'b0;
      fm_mode                 <= 1'b0;
      low_band_driver_output  <= 1'b0;
      high_band_driver_output <= 1'b0;
      charge_pump_boost_hold  <= 1'b0;
      oscillator_port_pick    <= 1'b0;
      baseband_level_select   <= 1'b0;
    end
    else
    begin
      main_divider_ratio      <= main_reg;
      reference_divider_ratio <= ref_reg;
      config_word             <= cfg_reg;
      test_word               <= test_reg;
      serial_port_on          <= hw_on_s;
      bias_on                 <= core_on;
      synth_on                <= synth_ok;
      upconverter_on          <= tx_ok;
      iq_modulator_on         <= tx_ok & op_reg[`SCRB_OP_MODTYPE];
      direct_vco_mod          <= tx_ok & ~op_reg[`SCRB_OP_MODTYPE];
      buffered_osc_output     <= synth_ok & op_reg[`SCRB_OP_BUF_EN];
      buffered_osc_half       <= cfg_reg[`SCRB_CFG_BUF_DIV];
      intermediate_gain_step  <= op_reg[`SCRB_OP_IFG_MSB:`SCRB_OP_IFG_LSB];
      upper_sideband          <= op_reg[`SCRB_OP_SIDEBAND];
      fm_mode                 <= (band_mode == `SCRB_MODE_FM);
      low_band_driver_output  <= tx_ok & (band_mode == `SCRB_MODE_CELL);
      high_band_driver_output <= tx_ok & (band_mode == `SCRB_MODE_PCS);
      charge_pump_boost_hold  <= synth_ok & op_reg[`SCRB_OP_CP_BOOST];
      oscillator_port_pick    <= op_reg[`SCRB_OP_LO_PICK];
      baseband_level_select   <= cfg_reg[`SCRB_CFG_BB_LVL];
    end
  end

endmodule

`default_nettype wire

// File: verif/scrb_host.sv
// host-side model that writes words over the three-wire serial bus
`default_nettype none
module scrb_host
(
  input  wire logic ref_clk,
  output var  logic ser_select_n,
  output var  logic ser_clk,
  output var  logic ser_data
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // frame generation
  // ----------------------------------------
  initial
  begin
    ser_select_n = 1'b1;
    ser_clk = 1'b0;
    ser_data = 1'b0;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic send(input logic [23:0] w, input logic [3:0] pre, input int npre);
    logic [27:0] s;
    s = {pre, w};
    ser_select_n <= 1'b0;
    wait_clk(4);
    for (int i = 23 + npre; i >= 0; i--)
    begin
      ser_data <= s[i];
      wait_clk(4);
      ser_clk <= 1'b1;
      wait_clk(4);
      ser_clk <= 1'b0;
    end
    wait_clk(4);
    ser_select_n <= 1'b1;
    // released data line shows no stale level
    ser_data <= ~ser_data;
    wait_clk(8);
  endtask
endmodule
`default_nettype wire

// File: verif/scrb_top_properties.sv
// concurrent checks on the register bank outputs
`default_nettype none
module scrb_top_properties
(
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        ser_select_n,
  input wire logic        hardware_powerdown_pin_n,
  input wire logic        transmit_gate_pin,
  input wire logic [19:0] main_divider_ratio,
  input wire logic        serial_port_on,
  input wire logic        bias_on,
  input wire logic        synth_on,
  input wire logic        upconverter_on,
  input wire logic        iq_modulator_on,
  input wire logic        direct_vco_mod,
  input wire logic        buffered_osc_output,
  input wire logic        fm_mode,
  input wire logic        low_band_driver_output,
  input wire logic        high_band_driver_output,
  input wire logic        charge_pump_boost_hold
);
  timeunit 1ns;
  timeprecision 100ps;
  // bus idle and pin high together
  wire idle_bus = ser_select_n && hardware_powerdown_pin_n;
  // ----------------------------------------
  // power and decode relations
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  bias_port_a: assert property (bias_on |-> serial_port_on)
    else $error("bias on with port off");
  synth_bias_a: assert property (synth_on |-> bias_on)
    else $error("synth on without bias");
  tx_synth_a: assert property (upconverter_on |-> synth_on)
    else $error("upconverter on without synth");
  mod_path_a: assert property (upconverter_on |-> iq_modulator_on != direct_vco_mod)
    else $error("modulation path not unique");
  mod_idle_a: assert property (!upconverter_on |-> !iq_modulator_on && !direct_vco_mod)
    else $error("modulator on while idle");
  band_excl_a: assert property (fm_mode |-> !low_band_driver_output && !high_band_driver_output)
    else $error("driver on in fm mode");
  osc_buf_a: assert property (buffered_osc_output |-> synth_on)
    else $error("buffer on without synth");
  cp_hold_a: assert property (charge_pump_boost_hold |-> synth_on)
    else $error("boost on without synth");
  hw_off_a: assert property (!hardware_powerdown_pin_n [*5] |-> !serial_port_on && !bias_on)
    else $error("outputs alive with pin low");
  gate_off_a: assert property (!transmit_gate_pin [*5] |-> !upconverter_on)
    else $error("upconverter on with gate low");
  word_hold_a: assert property (idle_bus [*8] |-> $stable(main_divider_ratio))
    else $error("register moved without frame");
  cover property (low_band_driver_output);
  cover property (high_band_driver_output);
  cover property (!serial_port_on);
endmodule
bind scrb_top scrb_top_properties chk_u (.ref_clk, .rst_n, .ser_select_n, .hardware_powerdown_pin_n,
  .transmit_gate_pin, .main_divider_ratio, .serial_port_on, .bias_on, .synth_on, .upconverter_on,
  .iq_modulator_on, .direct_vco_mod, .buffered_osc_output, .fm_mode, .low_band_driver_output,
  .high_band_driver_output, .charge_pump_boost_hold);
`default_nettype wire

// File: verif/serial_control_register_bank_tb.sv
// self-checking bench for the serial control register bank
`include "scrb_map.vh"
`default_nettype none
module serial_control_register_bank_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        ref_clk, rst_n, hardware_powerdown_pin_n, transmit_gate_pin, ser_select_n, ser_clk, ser_data;
  logic [19:0] main_divider_ratio, reference_divider_ratio, config_word, test_word;
  logic        serial_port_on, bias_on, synth_on, upconverter_on, iq_modulator_on, direct_vco_mod;
  logic        buffered_osc_output, buffered_osc_half, upper_sideband, fm_mode, low_band_driver_output;
  logic        high_band_driver_output, charge_pump_boost_hold, oscillator_port_pick, baseband_level_select;
  logic [2:0]  intermediate_gain_step;
  int          num_errors = 0;
  int          n_compared = 0;
  int          cycles = 0;
  // ----------------------------------------
  // instances and clock
  // ----------------------------------------
  scrb_top dut_u (.ref_clk, .rst_n, .ser_select_n, .ser_clk, .ser_data, .hardware_powerdown_pin_n,
    .transmit_gate_pin, .main_divider_ratio, .reference_divider_ratio, .config_word, .test_word,
    .serial_port_on, .bias_on, .synth_on, .upconverter_on, .iq_modulator_on, .direct_vco_mod,
    .buffered_osc_output, .buffered_osc_half, .intermediate_gain_step, .upper_sideband, .fm_mode,
    .low_band_driver_output, .high_band_driver_output, .charge_pump_boost_hold, .oscillator_port_pick,
    .baseband_level_select);
  scrb_host host_u (.ref_clk, .ser_select_n, .ser_clk, .ser_data);
  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      end_of_test();
    end
  end
  // ----------------------------------------
  // helpers and scenarios
  // ----------------------------------------
  task automatic chk(input logic [19:0] seen, input logic [19:0] exp, input string what);
    n_compared++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [19:0] d);
    host_u.send({d, a}, 4'h0, 0);
  endtask
  task automatic t_regs();
    wr(`SCRB_ADDR_MAIN, 20'hABCDE);
    wr(`SCRB_ADDR_REF, 20'h12345);
    wr(`SCRB_ADDR_CFG, 20'hFFFFC);
    chk({buffered_osc_half, baseband_level_select}, 20'h0, "cfg care");
    chk(config_word, 20'hFFFFC, "cfg word");
    wr(`SCRB_ADDR_CFG, 20'h00003);
    wr(`SCRB_ADDR_TEST, 20'hFFFFF);
    wr(4'h5, 20'h55555);
    chk(main_divider_ratio, 20'hABCDE, "main");
    chk(reference_divider_ratio, 20'h12345, "ref");
    chk(buffered_osc_half, 20'h1, "cfg half");
    chk(baseband_level_select, 20'h1, "cfg level");
    chk(config_word, 20'h00003, "cfg back");
    chk(test_word, 20'hFFFFF, "test");
    host_u.send({20'h2468A, `SCRB_ADDR_MAIN}, 4'hF, 4);
    chk(main_divider_ratio, 20'h2468A, "long");
  endtask
  task automatic t_modes();
    logic [1:0]  m;
    logic [19:0] d;
    for (int i = 0; i < 4; i++)
    begin
      m = i[1:0];
      d = {4'h0, m[1], 1'b0, m[1], m, 2'b00, m, 1'b1, m[0], m[0], ~m[0], 3'b111};
      wr(`SCRB_ADDR_OPERATIONAL_CONTROL, d);
      chk(fm_mode, 20'(m == 2'h0), "fm");
      chk(low_band_driver_output, 20'(m == 2'h1), "low");
      chk(high_band_driver_output, 20'(m == 2'h3), "high");
      chk(intermediate_gain_step, {m, 1'b1}, "gain");
      chk(upper_sideband, m[0], "side");
      chk(buffered_osc_output, m[0], "buf");
      chk(direct_vco_mod, m[0], "direct");
      chk(charge_pump_boost_hold, m[1], "boost");
      chk(oscillator_port_pick, m[1], "port");
    end
  endtask
  task automatic t_power();
    wr(`SCRB_ADDR_OPERATIONAL_CONTROL, 20'h0001B);
    chk({bias_on, synth_on, buffered_osc_output}, 20'h4, "register_retaining_standby");
    chk(main_divider_ratio, 20'h2468A, "kept");
    wr(`SCRB_ADDR_OPERATIONAL_CONTROL, 20'h0001D);
    chk({synth_on, upconverter_on, iq_modulator_on}, 20'h4, "transmit_path_standby");
    wr(`SCRB_ADDR_OPERATIONAL_CONTROL, 20'h0001F);
    transmit_gate_pin <= 1'b0;
    repeat (6) @(posedge ref_clk);
    chk({synth_on, upconverter_on}, 20'h2, "gate");
    transmit_gate_pin <= 1'b1;
    wr(`SCRB_ADDR_OPERATIONAL_CONTROL, 20'h0001E);
    chk(serial_port_on, 20'h1, "soft port");
    chk(bias_on, 20'h0, "soft bias");
    chk(main_divider_ratio, 20'h0, "soft main");
    wr(`SCRB_ADDR_MAIN, 20'h11111);
    chk(main_divider_ratio, 20'h0, "ignored");
    wr(`SCRB_ADDR_OPERATIONAL_CONTROL, 20'h0001F);
    wr(`SCRB_ADDR_MAIN, 20'h13579);
    chk(bias_on, 20'h1, "wake bias");
    chk(main_divider_ratio, 20'h13579, "wake main");
    hardware_powerdown_pin_n <= 1'b0;
    repeat (8) @(posedge ref_clk);
    chk(serial_port_on, 20'h0, "hw port");
    chk(main_divider_ratio, 20'h0, "hw main");
    hardware_powerdown_pin_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    wr(`SCRB_ADDR_REF, 20'h00042);
    chk(reference_divider_ratio, 20'h00042, "rewrite");
  endtask
  task automatic end_of_test();
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    rst_n = 1'b0;
    hardware_powerdown_pin_n = 1'b1;
    transmit_gate_pin = 1'b1;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge ref_clk);
    chk({intermediate_gain_step, low_band_driver_output, oscillator_port_pick}, 20'h13, "reset");
    t_regs();
    t_modes();
    t_power();
    end_of_test();
  end
endmodule
`default_nettype wire
